// file: hw/pwm_timer.sv
// autoreload pwm timer with capture, one-pulse and break, axi4-lite slave
//
// Overview of operation
// - capture flag set on capture, cleared only by reading a capture byte
// - capture request while capture enable and capture flag both set
// - two-bit clock select: off, slow timebase, cpu clock; zero at reset
// - overflow flag set at FFFh to reload, cleared by control read; gated request
// - compare request when any compare flag and compare enable set
// - read-only 12-bit up-counter, zero at reset, counts selected ticks
// - overflow reloads counter from software reload value, setting pwm period
// - output enable per channel selects pwm; clear releases the pin
// - one-pulse enable for channels 2 and 3, only in channel-3 register
// - one-pulse trigger edge: 0 falling, 1 rising, only with one-pulse on
// - per-channel polarity bit inverts pwm output; zero at reset
// - compare flag set on counter equal active duty, cleared by channel read
// - break level select: 0 low active, 1 high active; zero at reset
// - break-active writable, set by hardware from break pin; zero at reset
// - break pin enable gates the break input; zero at reset
// - during break enabled channels drive their break pattern bit
// - 12-bit duty value sets duty cycle or compare value per channel
// - capture edge copies counter into read-only capture value
// - new capture only while capture flag clear
// - capture source select: 0 own pin, 1 shared pin
// - preload duty and polarity move to active copies at overflow if enabled
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "pwm_timer_regs.svh"

module pwm_timer #(
  parameter int unsigned SLOW_CYCLES =
    `SLOW_PERIOD_US * `NS_PER_US / `CLK_PERIOD_NS,
  parameter int unsigned ADDR_W      = 8
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // pins
  input  wire logic              own_capture_pin,
  input  wire logic              shared_capture_pin,
  input  wire logic              break_pin,
  output logic [3:0]             pwm_channel_output,
  output logic [3:0]             pwm_output_active,
  // requests
  output logic                   capture_irq,
  output logic                   overflow_irq,
  output logic                   compare_irq
);

  if (SLOW_CYCLES < 2 || ADDR_W < 8) begin : g_bad_param
    $error("pwm_timer: SLOW_CYCLES must be >= 2 and ADDR_W >= 8");
  end

  localparam logic [31:0] SLOW_LAST = 32'(SLOW_CYCLES - 1);

  pwm_timer_pkg::state_t state_reg;
  pwm_timer_pkg::state_t state_next;

  logic       tick;
  logic       trig;
  logic       ovf_evt;
  logic       ar_fire;
  logic [5:0] rd_idx;
  logic [2:0] chg;

  function automatic logic is_mapped(input logic [5:0] i);
    is_mapped = (i >= `IDX_CTRL) && (i <= `IDX_MISC);
  endfunction

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    pwm_timer_pkg::state_t s;
    logic       wr;
    logic       we;
    logic [5:0] wi;
    logic [7:0] wd;
    logic [7:0] rv;
    logic [3:0] cmp_clr;
    logic [3:0] cmp_set;
    logic       ovf_clr;
    logic       cap_clr;
    logic       cap_edge;
    logic [5:0] off;
    logic [1:0] ch;
    s        = state_reg;
    wr       = 1'b0;
    we       = 1'b0;
    wi       = state_reg.aw_idx;
    wd       = state_reg.w_data;
    rv       = `RST_ZERO;
    cmp_clr  = 4'h0;
    cmp_set  = 4'h0;
    ovf_clr  = 1'b0;
    cap_clr  = 1'b0;
    cap_edge = 1'b0;
    off      = 6'h00;
    ch       = 2'b00;

    // input synchronisers: a change counts once stages two and three agree
    s.s1   = {break_pin, shared_capture_pin, own_capture_pin};
    s.s2   = state_reg.s1;
    s.s3   = state_reg.s2;
    chg    = ~(state_reg.s2 ^ state_reg.s3) & (state_reg.s3 ^ state_reg.filt);
    s.filt = state_reg.filt ^ chg;

    // write channel: address and data taken in either order
    if (awvalid && state_reg.awready) begin
      s.aw_held = 1'b1;
      s.aw_idx  = awaddr[7:2];
    end
    if (wvalid && state_reg.wready) begin
      s.w_held = 1'b1;
      s.w_data = wdata[7:0];
      s.w_en   = wstrb[0];
    end
    if (state_reg.bvalid && bready) begin
      s.bvalid = 1'b0;
    end
    wr = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    if (wr) begin
      s.aw_held = 1'b0;
      s.w_held  = 1'b0;
      s.bvalid  = 1'b1;
      s.bresp   = is_mapped(wi) ? 2'b00 : 2'b10;
    end
    we = wr && state_reg.w_en && is_mapped(wi);

    // read channel
    ar_fire = arvalid && state_reg.arready;
    rd_idx  = araddr[7:2];
    case (rd_idx)
      `IDX_CTRL: rv = {1'b0, state_reg.cap_flag, state_reg.cap_ie, state_reg.clk_sel,
                       state_reg.ovf_flag, state_reg.ovf_ie, state_reg.cmp_ie};
      `IDX_CNT_H:    rv = {4'h0, state_reg.cnt[11:8]};
      `IDX_CNT_L:    rv = state_reg.cnt[7:0];
      `IDX_RELOAD_H: rv = {4'h0, state_reg.reload[11:8]};
      `IDX_RELOAD_L: rv = state_reg.reload[7:0];
      `IDX_OE: rv = {1'b0, state_reg.oe[3], 1'b0, state_reg.oe[2],
                     1'b0, state_reg.oe[1], 1'b0, state_reg.oe[0]};
      `IDX_CAP_H: rv = {4'h0, state_reg.capture[11:8]};
      `IDX_CAP_L: rv = state_reg.capture[7:0];
      `IDX_BRK: rv = {1'b0, state_reg.brk_level, state_reg.brk_active,
                      state_reg.brk_pin_en, state_reg.brk_pattern};
      `IDX_MISC: rv = {6'h00, state_reg.xfer_en, state_reg.cap_src};
      default: begin
        if (rd_idx >= `IDX_CH0 && rd_idx <= `IDX_CH3) begin
          off = rd_idx - `IDX_CH0;
          ch  = off[1:0];
          rv  = {4'h0, (ch == 2'd3) ? {state_reg.pulse_en, state_reg.pulse_edge} : 2'b00,
                 state_reg.pol_pre[ch], state_reg.cmpf[ch]};
        end else if (rd_idx >= `IDX_DUTY0_H && rd_idx <= `IDX_DUTY3_L) begin
          off = rd_idx - `IDX_DUTY0_H;
          ch  = off[2:1];
          rv  = off[0] ? state_reg.duty_pre[ch][7:0] : {4'h0, state_reg.duty_pre[ch][11:8]};
        end
      end
    endcase
    if (state_reg.rvalid && rready) begin
      s.rvalid = 1'b0;
    end
    if (ar_fire) begin
      s.rvalid = 1'b1;
      s.rdata  = {24'h00_0000, rv};
      s.rresp  = is_mapped(rd_idx) ? 2'b00 : 2'b10;
      ovf_clr  = (rd_idx == `IDX_CTRL);
      cap_clr  = (rd_idx == `IDX_CAP_H) || (rd_idx == `IDX_CAP_L);
      if (rd_idx >= `IDX_CH0 && rd_idx <= `IDX_CH3) begin
        off     = rd_idx - `IDX_CH0;
        cmp_clr = 4'h1 << off[1:0];
      end
    end
    s.arready = !s.rvalid;
    s.awready = !s.aw_held && !s.bvalid;
    s.wready  = !s.w_held && !s.bvalid;

    // counter clock: slow ticks come from a divider
    s.div = (state_reg.clk_sel == pwm_timer_pkg::CLK_SLOW && state_reg.div != SLOW_LAST) ?
            state_reg.div + 32'h0000_0001 : 32'h0000_0000;
    tick  = (state_reg.clk_sel == pwm_timer_pkg::CLK_CPU) ||
            (state_reg.clk_sel == pwm_timer_pkg::CLK_SLOW && state_reg.div == SLOW_LAST);
    trig  = state_reg.pulse_en && state_reg.clk_sel != pwm_timer_pkg::CLK_OFF &&
            chg[1] && (s.filt[1] == state_reg.pulse_edge) && !state_reg.raw[3];
    ovf_evt = tick && !trig && state_reg.cnt == `CNT_TOP;
    if (trig) begin
      s.cnt = 12'h000;
    end else if (tick) begin
      s.cnt = ovf_evt ? state_reg.reload : state_reg.cnt + 12'h001;
    end

    // preload transfer at overflow, enable cleared after each transfer
    if (ovf_evt && state_reg.xfer_en) begin
      s.duty_act = state_reg.duty_pre;
      s.pol_act  = state_reg.pol_pre;
      s.xfer_en  = 1'b0;
    end

    // software writes
    if (we) begin
      case (wi)
        `IDX_CTRL: begin
          s.cap_ie  = wd[`CTRL_CAP_IE];
          s.clk_sel = pwm_timer_pkg::clk_sel_t'(wd[`CTRL_CLK_LSB +: 2]);
          s.ovf_ie  = wd[`CTRL_OVF_IE];
          s.cmp_ie  = wd[`CTRL_CMP_IE];
        end
        `IDX_RELOAD_H: s.reload[11:8] = wd[3:0];
        `IDX_RELOAD_L: s.reload[7:0]  = wd;
        `IDX_OE: s.oe = {wd[6], wd[4], wd[2], wd[0]};
        `IDX_BRK: begin
          s.brk_level   = wd[`BRK_LEVEL];
          s.brk_active  = wd[`BRK_ACTIVE];
          s.brk_pin_en  = wd[`BRK_PIN_EN];
          s.brk_pattern = wd[3:0];
        end
        `IDX_MISC: begin
          s.cap_src = wd[`MISC_SRC];
          s.xfer_en = wd[`MISC_XFER];
        end
        default: begin
          if (wi >= `IDX_CH0 && wi <= `IDX_CH3) begin
            off = wi - `IDX_CH0;
            ch  = off[1:0];
            s.pol_pre[ch] = wd[`CH_POL];
            if (ch == 2'd3) begin
              s.pulse_en   = wd[`CH_PULSE_EN];
              s.pulse_edge = wd[`CH_PULSE_EDGE];
            end
          end else if (wi >= `IDX_DUTY0_H && wi <= `IDX_DUTY3_L) begin
            off = wi - `IDX_DUTY0_H;
            ch  = off[2:1];
            if (off[0]) begin
              s.duty_pre[ch][7:0] = wd;
            end else begin
              s.duty_pre[ch][11:8] = wd[3:0];
            end
          end
        end
      endcase
    end

    // pwm edges and compare flags
    for (int i = 0; i < 4; i++) begin
      if ((tick || trig) && s.cnt == s.duty_act[i]) begin
        s.raw[i]   = 1'b0;
        cmp_set[i] = 1'b1;
      end else if (ovf_evt || (trig && i >= 2)) begin
        s.raw[i] = 1'b1;
      end
    end

    // capture on either edge of the selected pin
    cap_edge = state_reg.cap_src ? chg[1] : chg[0];
    if (cap_edge && !state_reg.cap_flag) begin
      s.capture = state_reg.cnt;
    end

    // flags: a hardware set wins over a read clear for overflow and compare flags; for the capture flag the read clear wins
    s.cap_flag = (state_reg.cap_flag && !cap_clr) || (cap_edge && !state_reg.cap_flag);
    s.ovf_flag = (state_reg.ovf_flag && !ovf_clr) || ovf_evt;
    s.cmpf     = (state_reg.cmpf & ~cmp_clr) | cmp_set;
    s.brk_active = s.brk_active ||
                   (state_reg.brk_pin_en && state_reg.filt[2] == state_reg.brk_level);

    // outputs
    for (int i = 0; i < 4; i++) begin
      s.pwm_en[i]  = s.oe[i];
      s.pwm_out[i] = s.oe[i] && (s.brk_active ? s.brk_pattern[i] :
                                 (s.raw[i] ^ s.pol_act[i]));
    end
    s.cap_irq = s.cap_flag && s.cap_ie;
    s.ovf_irq = s.ovf_flag && s.ovf_ie;
    s.cmp_irq = (|s.cmpf) && s.cmp_ie;
    state_next = s;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg         <= '0;
      state_reg.xfer_en <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign awready            = state_reg.awready;
  assign wready             = state_reg.wready;
  assign bvalid             = state_reg.bvalid;
  assign bresp              = state_reg.bresp;
  assign arready            = state_reg.arready;
  assign rvalid             = state_reg.rvalid;
  assign rdata              = state_reg.rdata;
  assign rresp              = state_reg.rresp;
  assign pwm_channel_output = state_reg.pwm_out;
  assign pwm_output_active  = state_reg.pwm_en;
  assign capture_irq        = state_reg.cap_irq;
  assign overflow_irq       = state_reg.ovf_irq;
  assign compare_irq        = state_reg.cmp_irq;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_cap_hold;
    state_reg.cap_flag && !(ar_fire && (rd_idx == `IDX_CAP_H || rd_idx == `IDX_CAP_L))
      |=> state_reg.cap_flag;
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture flag lost");

  property p_cap_irq;
    capture_irq == (state_reg.cap_flag && state_reg.cap_ie);
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture request wrong");

  property p_clk_off;
    state_reg.clk_sel == pwm_timer_pkg::CLK_OFF |=> $stable(state_reg.cnt);
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("counter moved while off");

  property p_reload;
    ovf_evt |=> state_reg.cnt == $past(state_reg.reload) && state_reg.ovf_flag;
  endproperty
  a_reload: assert property (p_reload) else $error("overflow reload wrong");

  property p_count;
    tick && !trig && state_reg.cnt != `CNT_TOP |=> state_reg.cnt == $past(state_reg.cnt) + 12'h001;
  endproperty
  a_count: assert property (p_count) else $error("counter did not step");

  property p_cap_frozen;
    state_reg.cap_flag |=> $stable(state_reg.capture);
  endproperty
  a_cap_frozen: assert property (p_cap_frozen) else $error("capture overwritten");

  property p_cmp_hold;
    state_reg.cmpf[0] && !(ar_fire && rd_idx == `IDX_CH0) |=> state_reg.cmpf[0];
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("compare flag lost");

  property p_break_out;
    state_reg.brk_active && state_reg.oe[1] |-> pwm_channel_output[1] == state_reg.brk_pattern[1];
  endproperty
  a_break_out: assert property (p_break_out) else $error("break pattern not driven");

  property p_break_pin;
    state_reg.brk_pin_en && state_reg.filt[2] == state_reg.brk_level |=> state_reg.brk_active;
  endproperty
  a_break_pin: assert property (p_break_pin) else $error("break not raised");

  property p_oe_off;
    !state_reg.oe[2] |-> !pwm_output_active[2] && !pwm_channel_output[2];
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("disabled channel driven");

  c_overflow: cover property (ovf_evt ##1 state_reg.ovf_flag);
  c_capture:  cover property ($rose(state_reg.cap_flag));
  c_trigger:  cover property (trig);
  c_break:    cover property ($rose(state_reg.brk_active));

endmodule

// file: hw/pwm_timer_pkg.sv
// types shared by the pwm timer
package pwm_timer_pkg;

  typedef enum logic [1:0] {
    CLK_OFF  = 2'b00,
    CLK_SLOW = 2'b01,
    CLK_CPU  = 2'b10
  } clk_sel_t;

  typedef struct packed {
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic              aw_held, w_held, w_en;
    logic [5:0]        aw_idx;
    logic [7:0]        w_data;
    logic [31:0]       div;
    logic [11:0]       cnt, reload, capture;
    clk_sel_t          clk_sel;
    logic              cap_flag, cap_ie, ovf_flag, ovf_ie, cmp_ie;
    logic              pulse_en, pulse_edge, cap_src, xfer_en;
    logic              brk_level, brk_active, brk_pin_en;
    logic [3:0]        brk_pattern, oe, pol_pre, pol_act, cmpf, raw;
    logic [3:0][11:0]  duty_pre, duty_act;
    logic [2:0]        s1, s2, s3, filt;
    logic [3:0]        pwm_out, pwm_en;
    logic              cap_irq, ovf_irq, cmp_irq;
  } state_t;

endpackage

// file: hw/pwm_timer_regs.svh
// register indices, field positions, reset values and timing for the pwm timer
`ifndef PWM_TIMER_REGS_SVH
`define PWM_TIMER_REGS_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define IDX_CTRL     6'h0D
`define IDX_CNT_H    6'h0E
`define IDX_CNT_L    6'h0F
`define IDX_RELOAD_H 6'h10
`define IDX_RELOAD_L 6'h11
`define IDX_OE       6'h12
`define IDX_CH0      6'h13
`define IDX_CH3      6'h16
`define IDX_DUTY0_H  6'h17
`define IDX_DUTY3_L  6'h1E
`define IDX_CAP_H    6'h1F
`define IDX_CAP_L    6'h20
`define IDX_BRK      6'h21
`define IDX_MISC     6'h22

// ****************************************
// field positions
// ****************************************
`define CTRL_CAP_FLAG  6
`define CTRL_CAP_IE    5
`define CTRL_CLK_LSB   3
`define CTRL_OVF_FLAG  2
`define CTRL_OVF_IE    1
`define CTRL_CMP_IE    0
`define CH_PULSE_EN    3
`define CH_PULSE_EDGE  2
`define CH_POL         1
`define CH_CMP_FLAG    0
`define BRK_LEVEL      6
`define BRK_ACTIVE     5
`define BRK_PIN_EN     4
`define MISC_SRC       0
`define MISC_XFER      1

// ****************************************
// reset values and timing
// ****************************************
`define RST_ZERO       8'h00
`define RST_MISC       8'h02
`define CNT_TOP        12'hFFF
`define CLK_PERIOD_NS  32'h0000_0005
`define SLOW_PERIOD_US 32'h0000_03E8
`define NS_PER_US      32'h0000_03E8

`endif

// file: tb/pin_partner.sv
// pin-side partner: drives the capture and break pins, measures pwm high time
`timescale 1ns/1ps

module pin_partner (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            rst_n,
  // requests from the bench
  input  wire logic            toggle_own,
  input  wire logic            toggle_shared,
  input  wire logic            break_level,
  // pins
  output logic                 own_capture_pin,
  output logic                 shared_capture_pin,
  output logic                 break_pin,
  input  wire logic [3:0]      pwm_channel_output,
  // measurement
  output logic [3:0][7:0]      high_len
);
  logic [3:0][7:0] run_len;

  // ****************************************
  // pins change only just after a rising edge
  // ****************************************
  always @(posedge clock) begin
    if (!rst_n) begin
      own_capture_pin    <= 1'b0;
      shared_capture_pin <= 1'b0;
      break_pin          <= 1'b1;
      high_len           <= '0;
      run_len            <= '0;
    end else begin
      own_capture_pin    <= own_capture_pin ^ toggle_own;
      shared_capture_pin <= shared_capture_pin ^ toggle_shared;
      break_pin          <= break_level;
      for (int i = 0; i < 4; i++) begin
        if (!pwm_channel_output[i]) begin
          if (run_len[i] != 8'h00) begin
            high_len[i] <= run_len[i];
          end
          run_len[i] <= 8'h00;
        end else begin
          run_len[i] <= run_len[i] + 8'h01;
        end
      end
    end
  end
endmodule

// file: tb/testbench.sv
// self-checking bench for the pwm timer register block
`timescale 1ns/1ps
`include "pwm_timer_regs.svh"

module testbench;
  logic            clock = 1'b0;
  logic            rst_n;
  logic [7:0]      awaddr, araddr;
  logic            awvalid, wvalid, bready, arvalid, rready;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [31:0]     wdata, rdata;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp, resp;
  logic            own_pin, shared_pin, brk_pin;
  logic            toggle_own, toggle_shared, break_level;
  logic [3:0]      pwm_out, pwm_act;
  logic            capture_irq, overflow_irq, compare_irq;
  logic [3:0][7:0] high_len;
  logic [7:0]      rd_val, v_lo;
  int              miscompares = 0;
  int              n_compared = 0;
  int              cyc = 0;
  int              t0, d;

  always #2.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  pwm_timer #(.SLOW_CYCLES(8), .ADDR_W(8)) pwm_timer_i (
    .clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .own_capture_pin(own_pin), .shared_capture_pin(shared_pin), .break_pin(brk_pin),
    .pwm_channel_output(pwm_out), .pwm_output_active(pwm_act),
    .capture_irq(capture_irq), .overflow_irq(overflow_irq), .compare_irq(compare_irq)
  );

  pin_partner pin_partner_i (
    .clock(clock), .rst_n(rst_n), .toggle_own(toggle_own), .toggle_shared(toggle_shared),
    .break_level(break_level), .own_capture_pin(own_pin), .shared_capture_pin(shared_pin),
    .break_pin(brk_pin), .pwm_channel_output(pwm_out), .high_len(high_len)
  );

  // ****************************************
  // comparison, bus cycles and pin helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] dat);
    @(posedge clock);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, dat};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [5:0] idx);
    @(posedge clock);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd_val = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rc(input logic [5:0] idx, input logic [7:0] exp);
    rd(idx);
    check($sformatf("reg %h", idx), {8'h00, rd_val}, {8'h00, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic pulse(input logic on_shared);
    @(posedge clock);
    toggle_own <= !on_shared;
    toggle_shared <= on_shared;
    @(posedge clock);
    toggle_own <= 1'b0;
    toggle_shared <= 1'b0;
    wait_cyc(8);
  endtask

  task automatic finish_test;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    finish_test;
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    {toggle_own, toggle_shared} = 2'b00;
    break_level = 1'b1;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 'h0D; i <= 'h21; i++) rc(i[5:0], 8'h00);
    rc(`IDX_MISC, `RST_MISC);
    rd(6'h00);
    check("unmapped rresp", 16'(resp), 16'h0002);
    wr(6'h23, 8'h5A);
    check("unmapped bresp", 16'(resp), 16'h0002);
    wr(`IDX_CTRL, 8'h08);
    t0 = cyc;
    wait_cyc(200);
    wr(`IDX_CTRL, 8'h00);
    d = (cyc - t0) / 8;
    rd(`IDX_CNT_L);
    check("slow count", 16'(int'(rd_val) >= d - 1 && int'(rd_val) <= d + 1), 16'h0001);
    wr(`IDX_RELOAD_H, 8'h0F);
    wr(`IDX_RELOAD_L, 8'hF0);
    rc(`IDX_RELOAD_H, 8'h0F);
    rc(`IDX_RELOAD_L, 8'hF0);
    wr(`IDX_DUTY0_H, 8'h0F);
    wr(`IDX_DUTY0_H + 6'h01, 8'hF8);
    wr(`IDX_DUTY0_H + 6'h02, 8'h0F);
    wr(`IDX_DUTY0_H + 6'h03, 8'hF8);
    wr(`IDX_CH0 + 6'h01, 8'h02);
    wr(`IDX_OE, 8'h05);
    wr(`IDX_CTRL, 8'h13);
    for (int i = 0; i < 5000 && overflow_irq !== 1'b1; i++) @(negedge clock);
    check("overflow irq", 16'(overflow_irq), 16'h0001);
    wait_cyc(60);
    check("ch0 high time", 16'(high_len[0]), 16'h0008);
    check("ch1 inverted", 16'(pwm_out[1] ^ pwm_out[0]), 16'h0001);
    check("pin ownership", 16'(pwm_act), 16'h0003);
    check("disabled outputs", 16'(pwm_out[3:2]), 16'h0000);
    check("compare irq", 16'(compare_irq), 16'h0001);
    wr(`IDX_CTRL, 8'h03);
    rc(`IDX_CTRL, 8'h07);
    rc(`IDX_CTRL, 8'h03);
    wait_cyc(3);
    check("overflow irq cleared", 16'(overflow_irq), 16'h0000);
    rc(`IDX_CH0, 8'h01);
    rc(`IDX_CH0, 8'h00);
    rc(`IDX_CH0 + 6'h01, 8'h03);
    rd(`IDX_CH0 + 6'h02);
    rd(`IDX_CH3);
    wait_cyc(3);
    check("compare irq cleared", 16'(compare_irq), 16'h0000);
    rc(`IDX_CNT_H, 8'h0F);
    rd(`IDX_CNT_L);
    v_lo = rd_val;
    check("counter low range", 16'(v_lo[7:4]), 16'h000F);
    wr(`IDX_CNT_L, 8'h55);
    rc(`IDX_CNT_L, v_lo);
    wr(`IDX_BRK, 8'h22);
    wait_cyc(4);
    check("break pattern", 16'(pwm_out), 16'h0002);
    rc(`IDX_BRK, 8'h22);
    wr(`IDX_BRK, 8'h13);
    wait_cyc(8);
    rc(`IDX_BRK, 8'h13);
    wr(`IDX_BRK, 8'h53);
    wait_cyc(8);
    rc(`IDX_BRK, 8'h73);
    check("break by pin", 16'(pwm_out), 16'h0003);
    break_level <= 1'b0;
    wait_cyc(8);
    wr(`IDX_BRK, 8'h03);
    wait_cyc(8);
    rc(`IDX_BRK, 8'h03);
    wr(`IDX_BRK, 8'h13);
    wait_cyc(8);
    rc(`IDX_BRK, 8'h33);
    break_level <= 1'b1;
    wait_cyc(8);
    wr(`IDX_BRK, 8'h00);
    rc(`IDX_BRK, 8'h00);
    wr(`IDX_CTRL, 8'h20);
    pulse(1'b0);
    check("capture irq", 16'(capture_irq), 16'h0001);
    wr(`IDX_CTRL, 8'h40);
    wait_cyc(3);
    check("capture irq masked", 16'(capture_irq), 16'h0000);
    rc(`IDX_CTRL, 8'h40);
    rc(`IDX_CAP_H, 8'h0F);
    rc(`IDX_CAP_L, v_lo);
    rc(`IDX_CTRL, 8'h00);
    wr(`IDX_MISC, 8'h01);
    pulse(1'b0);
    rc(`IDX_CTRL, 8'h00);
    pulse(1'b1);
    rc(`IDX_CTRL, 8'h40);
    wr(`IDX_CTRL, 8'h10);
    wait_cyc(5);
    wr(`IDX_CTRL, 8'h00);
    pulse(1'b1);
    rc(`IDX_CAP_L, v_lo);
    wr(`IDX_CH3, 8'h0C);
    rc(`IDX_CH3, 8'h0C);
    wr(`IDX_CH0 + 6'h02, 8'h0C);
    rc(`IDX_CH0 + 6'h02, 8'h00);
    wr(`IDX_DUTY3_L - 6'h01, 8'h0F);
    wr(`IDX_DUTY3_L, 8'hF0);
    wr(`IDX_MISC, 8'h03);
    wr(`IDX_CTRL, 8'h10);
    wait_cyc(40);
    rc(`IDX_CNT_H, 8'h0F);
    pulse(1'b1);
    rc(`IDX_CNT_H, 8'h00);
    finish_test;
  end
endmodule
